/* File: include/pmbc_pkg.sv */
/*
 * pmbc_pkg: constants shared by the power mode and boot control block.
 * Assumes a 100 MHz MCLK and word-aligned AHB-Lite register access.
 */
package pmbc_pkg;
    // register byte offsets
    localparam logic [7:0] PMBC_OFS_POWER_CONTROL = 8'h00;
    localparam logic [7:0] PMBC_OFS_PLL_CONTROL   = 8'h04;
    localparam logic [7:0] PMBC_OFS_STATUS        = 8'h08;
    localparam logic [7:0] PMBC_OFS_WAKE_CAUSE    = 8'h0C;
    // power control register fields
    localparam int PMBC_BIT_IDLE      = 0;
    localparam int PMBC_BIT_PDOWN     = 1;
    localparam int PMBC_BIT_SER_WAKE  = 2;
    localparam int PMBC_BIT_EXTERNAL_INTERRUPT_0_WAKE = 3;
    // pll control register field
    localparam int PMBC_BIT_OSCILLATOR_POWERDOWN_BIT    = 3;
    // wake cause fields
    localparam int PMBC_BIT_CAUSE_TIC  = 0;
    localparam int PMBC_BIT_CAUSE_SER  = 1;
    localparam int PMBC_BIT_CAUSE_EXTERNAL_INTERRUPT_0 = 2;
    localparam int PMBC_BIT_CAUSE_IRQ  = 3;
    // reset values
    localparam logic [7:0] PMBC_RST_POWER_CONTROL = 8'h00;
    localparam logic [7:0] PMBC_RST_PLL_CONTROL   = 8'h00;
    // AHB codes
    localparam logic [1:0] PMBC_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] PMBC_HSIZE_WORD    = 3'h2;
    // power modes, Gray along normal -> idle -> power-down
    typedef enum logic [1:0] {
        PMBC_NORMAL = 2'h0,
        PMBC_IDLE   = 2'h1,
        PMBC_PDOWN  = 2'h3
    } pmbc_mode_t;
endpackage : pmbc_pkg

/* File: verilog/pmbc_strap.sv */
/*
 * pmbc_strap: samples the program store strobe pin at reset release.
 * Assumes SYS_RST synchronous to clk; pin arrives asynchronous.
 */
`timescale 1ns/1ps
module pmbc_strap (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic strobe_pin,
    output logic      download_mode
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic rst_d;
        logic dl;
    } pmbc_strap_st_t;

    pmbc_strap_st_t cur_ff;
    pmbc_strap_st_t nxt_st;

    // sample only at the falling edge of reset; the latch holds through the next reset until its release
    always_comb begin
        nxt_st       = cur_ff;
        nxt_st.sync1 = strobe_pin;
        nxt_st.sync2 = cur_ff.sync1;
        nxt_st.rst_d = rst;
        if (cur_ff.rst_d && !rst) begin
            nxt_st.dl = !cur_ff.sync2; // low strap selects download/debug
        end
    end

    // second stage alone is read, so the sample is never metastable
    always_ff @(posedge clk) begin
        cur_ff <= nxt_st;
    end

    assign download_mode = cur_ff.dl;
endmodule : pmbc_strap

/* File: verilog/pmbc_top.sv */
/*
 * pmbc_top: power mode controller and boot strap sampler.
 * Assumes an AHB-Lite master on MCLK, wake pulses from peripherals on
 * MCLK, and external pin inputs that are asynchronous.
 */
// Register access over AHB-Lite and the address map were decided locally.
`timescale 1ns/1ps
module pmbc_top
    import pmbc_pkg::*;
(
    input  wire logic        MCLK,
    input  wire logic        SYS_RST,
    input  wire logic        HSEL,
    input  wire logic [7:0]  HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic        TIC_IRQ,
    input  wire logic        SER_IRQ,
    input  wire logic        EXTERNAL_INTERRUPT_0_IRQ,
    input  wire logic        ANY_IRQ,
    input  wire logic        STROBE_PIN_IN,
    output logic             PLL_EN,
    output logic             CORE_CLK_EN,
    output logic             PERIPH_CLK_EN,
    output logic             OSC_EN,
    output logic             TIC_CLK_EN,
    output logic             PORT_HOLD,
    output logic             DAC_HOLD,
    output logic             DAC_HIZ,
    output logic             ADDR_STROBE_FORCE,
    output logic             ADDR_STROBE_LEVEL,
    output logic             STROBE_PIN_OUT,
    output logic             STROBE_PIN_OE,
    output logic             CORE_WAKE,
    output logic             DOWNLOAD_MODE
);
    // whole state of the block in one record, apart from the flops inside the strap sampler u_strap
    typedef struct packed {
        pmbc_mode_t  mode;
        logic [7:0]  power_control_reg;
        logic [7:0]  pll_control_reg;
        logic [3:0]  cause;
        logic        ph_wr;
        logic        ph_rd;
        logic [7:0]  ph_addr;
        logic [31:0] rdata;
        logic        pll_en;
        logic        core_en;
        logic        per_en;
        logic        osc_en;
        logic        tic_en;
        logic        port_hold;
        logic        dac_hold;
        logic        dac_hiz;
        logic        str_force;
        logic        str_level;
        logic        str_out;
        logic        str_oe;
        logic        wake;
        logic        dl;
        logic        tic_s1;
        logic        tic_s2;
        logic        ser_s1;
        logic        ser_s2;
        logic        external_interrupt_0_s1;
        logic        external_interrupt_0_s2;
    } pmbc_st_t;

    pmbc_st_t   cur_ff;
    pmbc_st_t   nxt_st;
    logic       strap_dl;
    logic       addr_ok;

    // strap sampler owns the strobe pin input path
    pmbc_strap u_strap (
        .clk           (MCLK),
        .rst           (SYS_RST),
        .strobe_pin    (STROBE_PIN_IN),
        .download_mode (strap_dl)
    );

    // word access decode for the register map
    function automatic logic [31:0] read_mux(input logic [7:0] a, input pmbc_st_t s);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (a)
            PMBC_OFS_POWER_CONTROL: v = {24'h00_0000, s.power_control_reg};
            PMBC_OFS_PLL_CONTROL:   v = {24'h00_0000, s.pll_control_reg};
            PMBC_OFS_STATUS:        v = {28'h000_0000, s.dl, 1'b0, s.mode};
            PMBC_OFS_WAKE_CAUSE:    v = {28'h000_0000, s.cause};
            default:                v = 32'h0000_0000;
        endcase
        return v;
    endfunction : read_mux

    assign addr_ok = HSEL && HREADY && (HTRANS == PMBC_HTRANS_NONSEQ)
                     && (HSIZE == PMBC_HSIZE_WORD);

    // mode sequencing, wake handling and register access
    always_comb begin
        logic tic_w;
        logic ser_w;
        logic external_interrupt_0_w;
        logic irq_w;
        logic [7:0] wpc;
        tic_w   = 1'b0;
        ser_w   = 1'b0;
        external_interrupt_0_w  = 1'b0;
        irq_w   = 1'b0;
        wpc     = 8'h00;
        nxt_st  = cur_ff;
        // wake inputs from pins pass two flops before use
        nxt_st.tic_s1  = TIC_IRQ;
        nxt_st.tic_s2  = cur_ff.tic_s1;
        nxt_st.ser_s1  = SER_IRQ;
        nxt_st.ser_s2  = cur_ff.ser_s1;
        nxt_st.external_interrupt_0_s1 = EXTERNAL_INTERRUPT_0_IRQ;
        nxt_st.external_interrupt_0_s2 = cur_ff.external_interrupt_0_s1;
        nxt_st.dl      = strap_dl;
        nxt_st.wake    = 1'b0;

        tic_w  = cur_ff.tic_s2;
        ser_w  = cur_ff.ser_s2 && cur_ff.power_control_reg[PMBC_BIT_SER_WAKE];
        external_interrupt_0_w = cur_ff.external_interrupt_0_s2 && cur_ff.power_control_reg[PMBC_BIT_EXTERNAL_INTERRUPT_0_WAKE];
        irq_w  = ANY_IRQ; // same-clock source, no synchroniser

        // bus write data phase
        if (cur_ff.ph_wr) begin
            unique case (cur_ff.ph_addr)
                PMBC_OFS_POWER_CONTROL: nxt_st.power_control_reg   = HWDATA[7:0];
                PMBC_OFS_PLL_CONTROL:   nxt_st.pll_control_reg = HWDATA[7:0];
                PMBC_OFS_WAKE_CAUSE:    nxt_st.cause  = cur_ff.cause & ~HWDATA[3:0];
                default: ;
            endcase
        end
        wpc = nxt_st.power_control_reg;

        // mode machine; a wake clears request bits after any write so it wins
        unique case (cur_ff.mode)
            PMBC_NORMAL: begin
                if (wpc[PMBC_BIT_PDOWN]) begin
                    nxt_st.mode = PMBC_PDOWN;
                end else if (wpc[PMBC_BIT_IDLE]) begin
                    nxt_st.mode = PMBC_IDLE;
                end
            end
            PMBC_IDLE: begin
                if (irq_w || tic_w || ser_w || external_interrupt_0_w) begin
                    nxt_st.mode = PMBC_NORMAL;
                    nxt_st.power_control_reg[PMBC_BIT_IDLE]  = 1'b0;
                    nxt_st.power_control_reg[PMBC_BIT_PDOWN] = 1'b0;
                    nxt_st.cause[PMBC_BIT_CAUSE_IRQ] = 1'b1;
                    nxt_st.wake = 1'b1;
                end
            end
            PMBC_PDOWN: begin
                // only these three interrupts reach a stopped core
                if (tic_w || ser_w || external_interrupt_0_w) begin
                    nxt_st.mode = PMBC_NORMAL;
                    nxt_st.power_control_reg[PMBC_BIT_IDLE]  = 1'b0;
                    nxt_st.power_control_reg[PMBC_BIT_PDOWN] = 1'b0;
                    nxt_st.wake = 1'b1; // core resumes via its handler
                    if (tic_w) nxt_st.cause[PMBC_BIT_CAUSE_TIC] = 1'b1;
                    if (ser_w) nxt_st.cause[PMBC_BIT_CAUSE_SER] = 1'b1;
                    if (external_interrupt_0_w) nxt_st.cause[PMBC_BIT_CAUSE_EXTERNAL_INTERRUPT_0] = 1'b1;
                end
            end
            default: nxt_st.mode = PMBC_NORMAL;
        endcase

        // clock gating and pin control follow the next mode
        unique case (nxt_st.mode)
            PMBC_IDLE: begin
                nxt_st.pll_en    = 1'b1;
                nxt_st.core_en   = 1'b0;
                nxt_st.per_en    = 1'b1;
                nxt_st.osc_en    = 1'b1;
                nxt_st.tic_en    = 1'b1;
                nxt_st.port_hold = 1'b1;
                nxt_st.dac_hold  = 1'b1;
                nxt_st.dac_hiz   = 1'b0;
                nxt_st.str_force = 1'b1;
                nxt_st.str_level = 1'b1;
                nxt_st.str_out   = 1'b1;
            end
            PMBC_PDOWN: begin
                nxt_st.pll_en    = 1'b0;
                nxt_st.core_en   = 1'b0;
                nxt_st.per_en    = 1'b0;
                nxt_st.osc_en    = !cur_ff.pll_control_reg[PMBC_BIT_OSCILLATOR_POWERDOWN_BIT];
                nxt_st.tic_en    = !cur_ff.pll_control_reg[PMBC_BIT_OSCILLATOR_POWERDOWN_BIT];
                nxt_st.port_hold = 1'b1;
                nxt_st.dac_hold  = 1'b0;
                nxt_st.dac_hiz   = 1'b1;
                nxt_st.str_force = 1'b1;
                nxt_st.str_level = 1'b0;
                nxt_st.str_out   = 1'b0;
            end
            default: begin
                nxt_st.pll_en    = 1'b1;
                nxt_st.core_en   = 1'b1;
                nxt_st.per_en    = 1'b1;
                nxt_st.osc_en    = 1'b1;
                nxt_st.tic_en    = 1'b1;
                nxt_st.port_hold = 1'b0;
                nxt_st.dac_hold  = 1'b0;
                nxt_st.dac_hiz   = 1'b0;
                nxt_st.str_force = 1'b0;
                nxt_st.str_level = 1'b1;
                nxt_st.str_out   = 1'b1;
            end
        endcase
        // the strobe pin is an output except while reset holds it for sampling
        nxt_st.str_oe = 1'b1;

        // address phase capture; zero wait states
        nxt_st.ph_wr   = addr_ok && HWRITE;
        nxt_st.ph_rd   = addr_ok && !HWRITE;
        nxt_st.ph_addr = HADDR;
        nxt_st.rdata   = addr_ok && !HWRITE ? read_mux(HADDR, cur_ff) : 32'h0000_0000;
    end

    // synchronous reset: every register to its default
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            cur_ff           <= '0;
            cur_ff.mode      <= PMBC_NORMAL;
            cur_ff.power_control_reg      <= PMBC_RST_POWER_CONTROL;
            cur_ff.pll_control_reg    <= PMBC_RST_PLL_CONTROL;
            cur_ff.pll_en    <= 1'b1;
            cur_ff.core_en   <= 1'b0; // core held while reset stands
            cur_ff.per_en    <= 1'b1;
            cur_ff.osc_en    <= 1'b1;
            cur_ff.tic_en    <= 1'b1;
            cur_ff.str_level <= 1'b1;
            cur_ff.str_out   <= 1'b1;
            cur_ff.str_oe    <= 1'b0; // pin released so the strap can be read
        end else begin
            cur_ff <= nxt_st;
        end
    end

    // every output straight from a flop, except HREADYOUT and HRESP which are constants
    assign HRDATA            = cur_ff.rdata;
    assign HREADYOUT         = 1'b1;
    assign HRESP             = 1'b0;
    assign PLL_EN            = cur_ff.pll_en;
    assign CORE_CLK_EN       = cur_ff.core_en;
    assign PERIPH_CLK_EN     = cur_ff.per_en;
    assign OSC_EN            = cur_ff.osc_en;
    assign TIC_CLK_EN        = cur_ff.tic_en;
    assign PORT_HOLD         = cur_ff.port_hold;
    assign DAC_HOLD          = cur_ff.dac_hold;
    assign DAC_HIZ           = cur_ff.dac_hiz;
    assign ADDR_STROBE_FORCE = cur_ff.str_force;
    assign ADDR_STROBE_LEVEL = cur_ff.str_level;
    assign STROBE_PIN_OUT    = cur_ff.str_out;
    assign STROBE_PIN_OE     = cur_ff.str_oe;
    assign CORE_WAKE         = cur_ff.wake;
    assign DOWNLOAD_MODE     = cur_ff.dl;
endmodule : pmbc_top

/* File: bench/pmbc_board.sv */
/* pmbc_board: board side of the block, the boot jumper and wake sources.
   Assumes requests come from the bench on the rising edge of clk. */
`timescale 1ns/1ps
module pmbc_board (
    input  wire logic       clk,
    input  wire logic       jumper_on,
    input  wire logic [2:0] wake_req,
    input  wire logic       strobe_out,
    input  wire logic       strobe_oe,
    output logic            strobe_pin,
    output logic [2:0]      wake_line
);
    logic [3:0] hold_ff [3] = '{4'h0, 4'h0, 4'h0};
    // pin pulled up; only the jumper pulls it low, device drive wins
    assign strobe_pin = strobe_oe ? strobe_out : !jumper_on;
    // each source holds its level six cycles so the synchroniser sees it
    always @(posedge clk) begin
        for (int i = 0; i < 3; i++) begin
            if (wake_req[i]) hold_ff[i] <= 4'h6;
            else if (hold_ff[i] != 4'h0) hold_ff[i] <= hold_ff[i] - 4'h1;
        end
    end
    for (genvar g = 0; g < 3; g++) begin : g_line
        assign wake_line[g] = (hold_ff[g] !== 4'h0) && (hold_ff[g] !== 4'hX);
    end
endmodule : pmbc_board

/* File: bench/pmbc_top_asserts.sv */
/* pmbc_top_asserts: port timing checks of the power mode controller.
   Bound to pmbc_top by the bench; sees top-level ports only. */
`timescale 1ns/1ps
module pmbc_top_asserts (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic ANY_IRQ,
    input wire logic TIC_IRQ,
    input wire logic PLL_EN,
    input wire logic CORE_CLK_EN,
    input wire logic PERIPH_CLK_EN,
    input wire logic OSC_EN,
    input wire logic TIC_CLK_EN,
    input wire logic PORT_HOLD,
    input wire logic DAC_HOLD,
    input wire logic DAC_HIZ,
    input wire logic ADDR_STROBE_FORCE,
    input wire logic ADDR_STROBE_LEVEL,
    input wire logic STROBE_PIN_OUT,
    input wire logic STROBE_PIN_OE,
    input wire logic CORE_WAKE,
    input wire logic DOWNLOAD_MODE
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    // core stopped with peripherals clocked means idle
    logic in_idle;
    assign in_idle = !CORE_CLK_EN && PERIPH_CLK_EN;
    rst_state_a: assert property ($past(SYS_RST) |-> !CORE_CLK_EN && !STROBE_PIN_OE)
        else $error("core clock or strobe drive on in reset");
    idle_pins_a: assert property (in_idle && !$past(SYS_RST) |-> ADDR_STROBE_FORCE
        && ADDR_STROBE_LEVEL && STROBE_PIN_OUT && PORT_HOLD && DAC_HOLD && !DAC_HIZ)
        else $error("idle pin states wrong");
    pd_pins_a: assert property (!PERIPH_CLK_EN |-> !PLL_EN && !CORE_CLK_EN && DAC_HIZ
        && PORT_HOLD && ADDR_STROBE_FORCE && !ADDR_STROBE_LEVEL && !STROBE_PIN_OUT)
        else $error("power-down pin states wrong");
    run_clocks_a: assert property (PERIPH_CLK_EN |-> PLL_EN && OSC_EN)
        else $error("pll or oscillator stopped outside power-down");
    osc_stop_a: assert property (!OSC_EN |-> !PERIPH_CLK_EN && !TIC_CLK_EN)
        else $error("oscillator stopped with clocks running");
    idle_exit_a: assert property (in_idle && ANY_IRQ && !$past(SYS_RST) |-> ##[1:3] CORE_CLK_EN)
        else $error("idle not left on interrupt");
    tic_exit_a: assert property (!PERIPH_CLK_EN && TIC_IRQ |-> ##[1:5] CORE_CLK_EN)
        else $error("power-down not left on interval counter");
    wake_pulse_a: assert property (CORE_WAKE |=> !CORE_WAKE && CORE_CLK_EN)
        else $error("wake pulse not single or core still stopped");
    strap_hold_a: assert property (!$past(SYS_RST) && !$past(SYS_RST, 2)
        && !$past(SYS_RST, 3) |-> $stable(DOWNLOAD_MODE))
        else $error("boot mode changed outside reset release");
endmodule : pmbc_top_asserts

/* File: bench/pmbc_top_tb.sv */
/* pmbc_top_tb: self-checking bench for the power mode and boot control.
   Assumes pmbc_pkg, the design, board model and checker compiled first. */
`timescale 1ns/1ps
module pmbc_top_tb
    import pmbc_pkg::*;
;
    logic        MCLK = 1'b0;
    logic        SYS_RST = 1'b1;
    logic        HSEL = 1'b0;
    logic [7:0]  HADDR = 8'h00;
    logic [1:0]  HTRANS = 2'h0;
    logic        HWRITE = 1'b0;
    logic [31:0] HWDATA = 32'h0;
    logic        ANY_IRQ = 1'b0;
    logic        jumper_on = 1'b0;
    logic [2:0]  wake_req = 3'h0;
    logic [2:0]  wake_line;
    logic [31:0] HRDATA;
    logic        HREADYOUT, HRESP, PLL_EN, CORE_CLK_EN, PERIPH_CLK_EN, OSC_EN, TIC_CLK_EN;
    logic        PORT_HOLD, DAC_HOLD, DAC_HIZ, ADDR_STROBE_FORCE, ADDR_STROBE_LEVEL;
    logic        STROBE_PIN_OUT, STROBE_PIN_OE, CORE_WAKE, DOWNLOAD_MODE, strobe_pin;
    int          mismatches = 0;
    int          checked = 0;
    always #5 MCLK = ~MCLK;
    // the slave's ready is the bus ready; size always a whole word
    pmbc_top dut (.MCLK, .SYS_RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(PMBC_HSIZE_WORD),
        .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .TIC_IRQ(wake_line[0]),
        .SER_IRQ(wake_line[1]), .EXTERNAL_INTERRUPT_0_IRQ(wake_line[2]), .ANY_IRQ, .STROBE_PIN_IN(strobe_pin),
        .PLL_EN, .CORE_CLK_EN, .PERIPH_CLK_EN, .OSC_EN, .TIC_CLK_EN, .PORT_HOLD, .DAC_HOLD,
        .DAC_HIZ, .ADDR_STROBE_FORCE, .ADDR_STROBE_LEVEL, .STROBE_PIN_OUT, .STROBE_PIN_OE,
        .CORE_WAKE, .DOWNLOAD_MODE);
    pmbc_board u_board (.clk(MCLK), .jumper_on, .wake_req, .strobe_out(STROBE_PIN_OUT),
        .strobe_oe(STROBE_PIN_OE), .strobe_pin, .wake_line);
    task automatic end_of_test;
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // one single transfer; ready sampled at each rising edge, never assumed
    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        q = 32'h0000_0000;
        @(posedge MCLK);
        HSEL   <= 1'b1;
        HADDR  <= a;
        HWRITE <= w;
        HTRANS <= PMBC_HTRANS_NONSEQ;
        // address phase stands until ready is seen high at a rising edge
        do begin
            @(posedge MCLK);
            n++;
        end while (HREADYOUT !== 1'b1 && n < 50);
        HSEL   <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        // data phase: read data taken at the edge that samples ready high
        do begin
            @(posedge MCLK);
            q = HRDATA;
            n++;
        end while (HREADYOUT !== 1'b1 && n < 100);
        if (n >= 100) begin
            mismatches++;
            end_of_test();
        end
    endtask : ahb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(a, 1'b1, d, q);
        repeat (2) @(negedge MCLK);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        ahb(a, 1'b0, 32'h0, q);
        chk(q, exp);
        chk(HRESP, 1'b0);
    endtask : rd
    task automatic chk_mode(input pmbc_mode_t m);
        logic [7:0] pins;
        pins = {PLL_EN, CORE_CLK_EN, PERIPH_CLK_EN, ADDR_STROBE_FORCE, ADDR_STROBE_LEVEL,
                STROBE_PIN_OUT, DAC_HIZ, PORT_HOLD};
        if (m == PMBC_NORMAL) chk(pins[7:5], 3'h7);
        else chk(pins, (m == PMBC_IDLE) ? 8'hBD : 8'h13);
    endtask : chk_mode
    // source 3 is the generic interrupt line, 0..2 the board wake lines
    task automatic wake_by(input int src, input logic exp);
        int n;
        n = 0;
        @(posedge MCLK);
        if (src == 3) ANY_IRQ <= 1'b1;
        else wake_req <= 3'(1 << src);
        @(posedge MCLK);
        ANY_IRQ  <= 1'b0;
        wake_req <= 3'h0;
        do begin
            @(negedge MCLK);
            n++;
        end while (CORE_CLK_EN !== 1'b1 && n < 12);
        chk(CORE_CLK_EN, exp);
        repeat (8) @(posedge MCLK);
    endtask : wake_by
    function automatic logic exp_wake(input int src, input logic [1:0] en);
        return src == 0 || (src == 1 && en[0]) || (src == 2 && en[1]);
    endfunction : exp_wake
    task automatic do_reset;
        @(posedge MCLK);
        SYS_RST <= 1'b1;
        repeat (6) @(posedge MCLK);
        SYS_RST <= 1'b0;
        repeat (4) @(negedge MCLK);
    endtask : do_reset
    initial begin
        logic [1:0] en;
        int src;
        void'($urandom(32'h8C144024));
        do_reset();
        chk(DOWNLOAD_MODE, 1'b0);
        chk(STROBE_PIN_OE, 1'b1);
        rd(PMBC_OFS_POWER_CONTROL, 32'h0);
        rd(8'h10, 32'h0);
        wr(PMBC_OFS_POWER_CONTROL, 32'h1);
        chk_mode(PMBC_IDLE);
        rd(PMBC_OFS_STATUS, 32'h1);
        wake_by(3, 1'b1);
        rd(PMBC_OFS_POWER_CONTROL, 32'h0);
        wr(PMBC_OFS_POWER_CONTROL, 32'h3);
        chk_mode(PMBC_PDOWN);
        rd(PMBC_OFS_STATUS, 32'h3);
        chk({OSC_EN, TIC_CLK_EN}, 2'h3);
        wake_by(3, 1'b0);
        wake_by(0, 1'b1);
        rd(PMBC_OFS_POWER_CONTROL, 32'h0);
        // four enable corners first, then random sources and enables
        for (int i = 0; i < 12; i++) begin
            src = (i < 4) ? 1 + i / 2 : $urandom_range(2);
            en = (i < 4) ? (i[0] ? 2'(src) : 2'h0) : 2'($urandom_range(3));
            wr(PMBC_OFS_POWER_CONTROL, 32'({en, 2'h2}));
            wake_by(src, exp_wake(src, en));
            if (!exp_wake(src, en)) wake_by(0, 1'b1);
        end
        wr(PMBC_OFS_PLL_CONTROL, 32'h8);
        wr(PMBC_OFS_POWER_CONTROL, 32'h2);
        chk({OSC_EN, TIC_CLK_EN}, 2'h0);
        do_reset();
        chk_mode(PMBC_NORMAL);
        rd(PMBC_OFS_PLL_CONTROL, 32'h0);
        @(posedge MCLK);
        jumper_on <= 1'b1;
        do_reset();
        chk(DOWNLOAD_MODE, 1'b1);
        rd(PMBC_OFS_STATUS, 32'h8);
        jumper_on <= 1'b0;
        repeat (5) @(negedge MCLK);
        chk(DOWNLOAD_MODE, 1'b1);
        do_reset();
        chk(DOWNLOAD_MODE, 1'b0);
        end_of_test();
    end
endmodule : pmbc_top_tb
bind pmbc_top pmbc_top_asserts u_chk (.MCLK, .SYS_RST, .ANY_IRQ, .TIC_IRQ, .PLL_EN,
    .CORE_CLK_EN, .PERIPH_CLK_EN, .OSC_EN, .TIC_CLK_EN, .PORT_HOLD, .DAC_HOLD, .DAC_HIZ,
    .ADDR_STROBE_FORCE, .ADDR_STROBE_LEVEL, .STROBE_PIN_OUT, .STROBE_PIN_OE, .CORE_WAKE,
    .DOWNLOAD_MODE);
